// ### rtl/twtu_pkg.sv
// twtu_pkg: constants for the two-wire target unit (read-command responder)
// assumes a 200 MHz system clock and an AHB-Lite register bus
`default_nettype none

package twtu_pkg;

  // ---------------------------------------------------------------
  // bus rates and clock
  // ---------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ = 200_000_000;
  localparam int unsigned STD_RATE_HZ = 100_000;
  localparam int unsigned FAST_RATE_HZ = 400_000;
  // system clocks per half bus period at the fast rate (rounded down)
  localparam int unsigned FAST_HALF_CYC = SYS_CLK_HZ / (2 * FAST_RATE_HZ);

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_TASK_STOP = 12'h014;
  localparam logic [11:0] OFS_TASK_SUSPEND = 12'h01c;
  localparam logic [11:0] OFS_TASK_RESUME = 12'h020;
  localparam logic [11:0] OFS_TASK_ARM_TX = 12'h034;
  localparam logic [11:0] OFS_EV_HALTED = 12'h104;
  localparam logic [11:0] OFS_EV_ERROR = 12'h124;
  localparam logic [11:0] OFS_EV_TX_BEGUN = 12'h150;
  localparam logic [11:0] OFS_EV_READ_CMD = 12'h168;
  localparam logic [11:0] OFS_ENABLE = 12'h500;
  localparam logic [11:0] OFS_TX_PTR = 12'h544;
  localparam logic [11:0] OFS_TX_MAXCNT = 12'h548;
  localparam logic [11:0] OFS_TX_AMOUNT = 12'h54c;
  localparam logic [11:0] OFS_CONFIG = 12'h554;
  localparam logic [11:0] OFS_ADDR0 = 12'h588;
  localparam logic [11:0] OFS_ADDR1 = 12'h58c;
  localparam logic [11:0] OFS_FILL_BYTE = 12'h5c0;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CFG_ADDR0_BIT = 0;
  localparam int unsigned CFG_ADDR1_BIT = 1;
  localparam logic [1:0] CONFIG_RESET = 2'h1;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [7:0] FILL_RESET = 8'h00;
  localparam logic [2:0] LAST_BIT = 3'h7;

endpackage : twtu_pkg

`default_nettype wire

// ### rtl/twtu_top.sv
// twtu_top: two-wire target that answers read commands from a bus master,
// fed by a byte-wide memory reader, with registers on AHB-Lite
// assumes open-drain pads resolved outside and a memory port that answers each request with memAck
//
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
`default_nettype none

module twtu_top
  import twtu_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // two-wire pins
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // memory read port
  output logic memReq,
  output logic [31:0] memAddr,
  input wire logic memAck,
  input wire logic [7:0] memRdata
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_CHK, ST_ACK, ST_LOAD, ST_TX, ST_TX_ACK, ST_RELEASE
  } twtu_state_t;

  typedef struct packed {
    logic scl1, scl2, scl3;
    logic sda1, sda2, sda3;
    twtu_state_t state;
    logic halting;
    logic [7:0] shift;
    logic [2:0] bitCnt;
    logic armed;
    logic txActive;
    logic suspended;
    logic byteReady;
    logic ackSeen;
    logic enable;
    logic [1:0] cfgBits;
    logic [6:0] addr0;
    logic [6:0] addr1;
    logic [7:0] fill;
    logic [31:0] ptr;
    logic [CNT_W-1:0] maxCnt;
    logic [31:0] ptrLat;
    logic [CNT_W-1:0] maxLat;
    logic [CNT_W-1:0] amount;
    logic evHalted, evError, evTxBegun, evReadCmd;
    logic memReq;
    logic [31:0] memAddr;
    logic wrPend;
    logic [11:0] wrAddr;
    logic [31:0] rdata;
    logic sdaOe;
    logic sclOe;
  } twtu_regs_t;

  twtu_regs_t r_reg;
  twtu_regs_t r_next;

  logic sclRise, sclFall, startCond, stopCond;
  logic addrPhase, stopTask, addrMatch;
  logic [31:0] rdMux;

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // zero wait states: every register answers in its data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r_reg.rdata;
  // open drain: both pins only ever pull low
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe = r_reg.sclOe;
  assign sdaOe = r_reg.sdaOe;
  assign memReq = r_reg.memReq;
  assign memAddr = r_reg.memAddr;

  // ---------------------------------------------------------------
  // bus condition detection
  // ---------------------------------------------------------------
  // edge finding on synced pins
  assign sclRise = r_reg.scl2 & ~r_reg.scl3;
  assign sclFall = ~r_reg.scl2 & r_reg.scl3;
  assign startCond = r_reg.scl2 & r_reg.scl3 & ~r_reg.sda2 & r_reg.sda3;
  assign stopCond = r_reg.scl2 & r_reg.scl3 & r_reg.sda2 & ~r_reg.sda3;

  assign addrMatch =
    (r_reg.cfgBits[CFG_ADDR0_BIT] && r_reg.shift[7:1] == r_reg.addr0) ||
    (r_reg.cfgBits[CFG_ADDR1_BIT] && r_reg.shift[7:1] == r_reg.addr1);

  assign addrPhase = hsel & htrans[1] & hready;
  assign stopTask = r_reg.wrPend && r_reg.wrAddr == OFS_TASK_STOP && hwdata[0];

  // ---------------------------------------------------------------
  // register read mux
  // ---------------------------------------------------------------
  always_comb
  begin
    rdMux = 32'h0000_0000;
    unique case (haddr[11:0])
      OFS_EV_HALTED: rdMux[0] = r_reg.evHalted;
      OFS_EV_ERROR: rdMux[0] = r_reg.evError;
      OFS_EV_TX_BEGUN: rdMux[0] = r_reg.evTxBegun;
      OFS_EV_READ_CMD: rdMux[0] = r_reg.evReadCmd;
      OFS_ENABLE: rdMux[0] = r_reg.enable;
      OFS_TX_PTR: rdMux = r_reg.ptr;
      OFS_TX_MAXCNT: rdMux[CNT_W-1:0] = r_reg.maxCnt;
      OFS_TX_AMOUNT: rdMux[CNT_W-1:0] = r_reg.amount;
      OFS_CONFIG: rdMux[1:0] = r_reg.cfgBits;
      OFS_ADDR0: rdMux[6:0] = r_reg.addr0;
      OFS_ADDR1: rdMux[6:0] = r_reg.addr1;
      OFS_FILL_BYTE: rdMux[7:0] = r_reg.fill;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    r_next = r_reg;
    r_next.scl1 = sclIn;
    r_next.scl2 = r_reg.scl1;
    r_next.scl3 = r_reg.scl2;
    r_next.sda1 = sdaIn;
    r_next.sda2 = r_reg.sda1;
    r_next.sda3 = r_reg.sda2;

    // bus slave: address phase captured, write done in data phase
    r_next.wrPend = addrPhase & hwrite;
    r_next.wrAddr = haddr[11:0];
    if (addrPhase && !hwrite)
      r_next.rdata = rdMux;

    if (r_reg.wrPend)
    begin
      unique case (r_reg.wrAddr)
        OFS_TASK_SUSPEND: if (hwdata[0]) r_next.suspended = 1'b1;
        OFS_TASK_RESUME: if (hwdata[0]) r_next.suspended = 1'b0;
        OFS_TASK_ARM_TX: if (hwdata[0]) r_next.armed = 1'b1;
        OFS_EV_HALTED: if (!hwdata[0]) r_next.evHalted = 1'b0;
        OFS_EV_ERROR: if (!hwdata[0]) r_next.evError = 1'b0;
        OFS_EV_TX_BEGUN: if (!hwdata[0]) r_next.evTxBegun = 1'b0;
        OFS_EV_READ_CMD: if (!hwdata[0]) r_next.evReadCmd = 1'b0;
        OFS_ENABLE: r_next.enable = hwdata[0];
        OFS_TX_PTR: r_next.ptr = hwdata;
        OFS_TX_MAXCNT: r_next.maxCnt = hwdata[CNT_W-1:0];
        OFS_CONFIG: r_next.cfgBits = hwdata[1:0];
        OFS_ADDR0: r_next.addr0 = hwdata[6:0];
        OFS_ADDR1: r_next.addr1 = hwdata[6:0];
        OFS_FILL_BYTE: r_next.fill = hwdata[7:0];
        default: r_next.enable = r_reg.enable;
      endcase
    end

    // memory reader; a late answer after a restart is simply dropped
    if (r_reg.memReq && memAck)
    begin
      r_next.memReq = 1'b0;
      if (r_reg.state == ST_LOAD)
      begin
        r_next.shift = memRdata;
        r_next.sdaOe = ~memRdata[7];
        r_next.byteReady = 1'b1;
      end
    end

    if (!r_reg.enable)
    begin
      r_next.state = ST_IDLE;
      r_next.sdaOe = 1'b0;
      r_next.sclOe = 1'b0;
      r_next.txActive = 1'b0;
    end
    else if (r_reg.halting)
    begin
      r_next.sdaOe = 1'b0;
      r_next.sclOe = 1'b0;
      if (!r_reg.memReq)
      begin
        r_next.halting = 1'b0;
        r_next.evHalted = 1'b1;
        r_next.armed = 1'b0;
        r_next.txActive = 1'b0;
        // a fetch answered during the halt must not leak into the next read
        r_next.byteReady = 1'b0;
        r_next.state = ST_IDLE;
      end
    end
    // stop task forces the same halt
    else if ((stopCond && r_reg.state != ST_IDLE) || stopTask)
    begin
      r_next.halting = 1'b1;
      r_next.armed = 1'b0;
      r_next.sdaOe = 1'b0;
      r_next.sclOe = 1'b0;
      r_next.byteReady = 1'b0;
    end
    // a start or restart goes straight to address
    // address phase begins from any state on a start
    else if (startCond)
    begin
      r_next.state = ST_ADDR;
      r_next.bitCnt = 3'h0;
      r_next.txActive = 1'b0;
      r_next.byteReady = 1'b0;
      r_next.sdaOe = 1'b0;
      r_next.sclOe = 1'b0;
    end
    else
    begin
      unique case (r_reg.state)
        // idle waits for a start
        // not addressed or done: wait for stop or restart
        ST_IDLE, ST_RELEASE:
        begin
          r_next.sdaOe = 1'b0;
          r_next.sclOe = 1'b0;
        end
        ST_ADDR:
        begin
          if (sclRise)
          begin
            r_next.shift = {r_reg.shift[6:0], r_reg.sda2};
            r_next.bitCnt = r_reg.bitCnt + 3'h1;
            if (r_reg.bitCnt == LAST_BIT)
              r_next.state = ST_ADDR_CHK;
          end
        end
        ST_ADDR_CHK:
        begin
          if (sclFall)
          begin
            if (addrMatch && r_reg.shift[0])
            begin
              r_next.sdaOe = 1'b1;
              r_next.evReadCmd = 1'b1;
              r_next.state = ST_ACK;
            end
            else
              r_next.state = ST_RELEASE;
          end
        end
        ST_ACK:
        begin
          if (sclFall)
          begin
            r_next.sdaOe = 1'b0;
            r_next.sclOe = 1'b1;
            r_next.state = ST_LOAD;
          end
        end
        // clock held low while loading a byte
        ST_LOAD:
        begin
          r_next.sclOe = 1'b1;
          if (!r_reg.txActive)
          begin
            if (r_reg.armed)
            begin
              r_next.armed = 1'b0;
              r_next.txActive = 1'b1;
              r_next.evTxBegun = 1'b1;
              r_next.ptrLat = r_reg.ptr;
              r_next.maxLat = r_reg.maxCnt;
              r_next.amount = '0;
            end
          end
          else if (r_reg.byteReady)
          begin
            // data has settled one cycle before the clock is let go
            r_next.byteReady = 1'b0;
            r_next.sclOe = 1'b0;
            r_next.bitCnt = 3'h0;
            r_next.state = ST_TX;
          end
          else if (!r_reg.suspended && !r_reg.memReq)
          begin
            if (r_reg.amount < r_reg.maxLat)
            begin
              r_next.memReq = 1'b1;
              r_next.memAddr = r_reg.ptrLat + 32'(r_reg.amount);
            end
            else
            begin
              r_next.shift = r_reg.fill;
              r_next.sdaOe = ~r_reg.fill[7];
              r_next.byteReady = 1'b1;
              r_next.evError = 1'b1;
            end
          end
        end
        // shift msb first on falling edge
        ST_TX:
        begin
          if (sclFall)
          begin
            if (r_reg.bitCnt == LAST_BIT)
            begin
              r_next.sdaOe = 1'b0;
              r_next.amount = r_reg.amount + 1'b1;
              r_next.state = ST_TX_ACK;
            end
            else
            begin
              r_next.shift = {r_reg.shift[6:0], 1'b0};
              r_next.sdaOe = ~r_reg.shift[6];
              r_next.bitCnt = r_reg.bitCnt + 3'h1;
            end
          end
        end
        ST_TX_ACK:
        begin
          if (sclRise)
            r_next.ackSeen = ~r_reg.sda2;
          if (sclFall)
          begin
            if (r_reg.ackSeen)
            begin
              r_next.sclOe = 1'b1;
              r_next.state = ST_LOAD;
            end
            else
              r_next.state = ST_RELEASE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      r_reg <= '0;
      r_reg.scl1 <= 1'b1;
      r_reg.scl2 <= 1'b1;
      r_reg.scl3 <= 1'b1;
      r_reg.sda1 <= 1'b1;
      r_reg.sda2 <= 1'b1;
      r_reg.sda3 <= 1'b1;
      r_reg.state <= ST_IDLE;
      r_reg.cfgBits <= CONFIG_RESET;
      r_reg.addr0 <= ADDR_RESET;
      r_reg.addr1 <= ADDR_RESET;
      r_reg.fill <= FILL_RESET;
    end
    else if (clkEn)
    begin
      r_reg <= r_next;
    end
  end

endmodule : twtu_top

`default_nettype wire

// ### testbench/tb.sv
// tb: registers over ahb-lite, master model on the pins, byte memory
// assumes one idle cycle between bus transfers
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import twtu_pkg::*;

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic memAck = 1'b0;
  logic [7:0] memRdata = 8'h0;
  logic [31:0] seed = 32'hb950;
  logic hreadyout, hresp, sclOe, sdaOe, memReq, mScl, mSda, sclW, sdaW;
  logic [31:0] hrdata, memAddr;
  logic [7:0] fill;
  logic [11:0] evs[4] = '{OFS_EV_HALTED, OFS_EV_ERROR, OFS_EV_TX_BEGUN, OFS_EV_READ_CMD};
  int n_errors = 0;
  int n_checks = 0;
  int wt = 0;

  assign sclW = ~(mScl | sclOe);
  assign sdaW = ~(mSda | sdaOe);

  twtu_top dut (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sclIn(sclW), .sclOut(),
    .sclOe(sclOe), .sdaIn(sdaW), .sdaOut(), .sdaOe(sdaOe), .memReq(memReq),
    .memAddr(memAddr), .memAck(memAck), .memRdata(memRdata));
  twtu_bus_master m (.sclW(sclW), .sdaW(sdaW), .sclPull(mScl), .sdaPull(mSda));

  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [7:0] memByte(input logic [31:0] a);
    return a[7:0] ^ 8'ha5;
  endfunction : memByte

  // memory answers after a random 1 to 3 cycles
  always @(posedge sys_clk)
  begin
    if (memReq === 1'b1 && memAck !== 1'b1 && wt == 0)
    begin
      memAck <= 1'b1;
      memRdata <= memByte(memAddr);
      wt <= int'(rnd() % 32'h3);
    end
    else
    begin
      memAck <= 1'b0;
      if (memReq === 1'b1 && memAck !== 1'b1)
        wt <= wt - 1;
    end
  end

  task automatic finish_test();
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rdChk

  // bytes past the limit must come as the fill byte; last one refused
  task automatic rdBytes(input int n, input logic [31:0] p, input int mx);
    logic [7:0] b;
    logic a;
    logic [7:0] expQ[$];
    for (int i = 0; i < n; i++)
      expQ.push_back(i < mx ? memByte(p + 32'(i)) : fill);
    for (int i = 0; i < n; i++)
    begin
      m.xfer(8'hff, i == n - 1, b, a);
      chk(32'(b), 32'(expQ.pop_front()));
    end
  endtask : rdBytes

  initial
  begin
    logic [31:0] r, ptr;
    logic [6:0] a0, a1;
    logic [7:0] b;
    logic ak;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rdChk(OFS_CONFIG, {30'h0, CONFIG_RESET});
    rdChk(OFS_TX_AMOUNT, 32'h0);
    rdChk(12'hffc, 32'h0);
    r = rnd();
    a0 = {3'h1, r[3:0]};
    a1 = {3'h5, r[7:4]};
    fill = r[15:8];
    ptr = rnd();
    wr(OFS_ADDR0, {25'h0, a0});
    wr(OFS_ADDR1, {25'h0, a1});
    wr(OFS_CONFIG, 32'h3);
    wr(OFS_FILL_BYTE, {24'h0, fill});
    wr(OFS_TX_PTR, ptr);
    wr(OFS_TX_MAXCNT, 32'h2);
    wr(OFS_ENABLE, 32'h1);
    m.start();
    m.xfer({7'h08, 1'b1}, 1'b1, b, ak);
    chk(32'(ak), 32'h1);
    m.stop();
    rdChk(OFS_EV_READ_CMD, 32'h0);
    m.start();
    m.xfer({a1, 1'b1}, 1'b1, b, ak);
    chk(32'(ak), 32'h0);
    fork
      rdBytes(4, ptr, 2);
      begin
        repeat (60) @(posedge sys_clk);
        chk(32'(sclW), 32'h0);
        rdChk(OFS_EV_TX_BEGUN, 32'h0);
        wr(OFS_TASK_ARM_TX, 32'h1);
        repeat (30) @(posedge sys_clk);
        wr(OFS_TX_PTR, ptr + 32'h40);
      end
    join
    m.stop();
    repeat (20) @(posedge sys_clk);
    rdChk(OFS_TX_AMOUNT, 32'h4);
    foreach (evs[i])
    begin
      rdChk(evs[i], 32'h1);
      wr(evs[i], 32'h0);
    end
    wr(OFS_TX_MAXCNT, 32'h3);
    wr(OFS_TASK_ARM_TX, 32'h1);
    wr(OFS_TASK_SUSPEND, 32'h1);
    m.start();
    m.xfer({a0, 1'b1}, 1'b1, b, ak);
    chk(32'(ak), 32'h0);
    fork
      rdBytes(2, ptr + 32'h40, 3);
      begin
        repeat (60) @(posedge sys_clk);
        chk(32'(sclW), 32'h0);
        chk(32'(memReq), 32'h0);
        rdChk(OFS_EV_TX_BEGUN, 32'h1);
        wr(OFS_TASK_RESUME, 32'h1);
      end
    join
    #60;
    chk(32'(sdaOe), 32'h0);
    chk(32'(sclOe), 32'h0);
    m.start();
    m.xfer({a0, 1'b1}, 1'b1, b, ak);
    chk(32'(ak), 32'h0);
    repeat (40) @(posedge sys_clk);
    chk(32'(sclOe), 32'h1);
    rdChk(OFS_EV_HALTED, 32'h0);
    // frozen clock enable: this stop task write must be lost
    clkEn <= 1'b0;
    wr(OFS_TASK_STOP, 32'h1);
    clkEn <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk(32'(sclOe), 32'h1);
    rdChk(OFS_EV_HALTED, 32'h0);
    wr(OFS_TASK_STOP, 32'h1);
    repeat (20) @(posedge sys_clk);
    chk(32'(sclOe), 32'h0);
    rdChk(OFS_EV_HALTED, 32'h1);
    m.stop();
    finish_test();
  end

  // the run needs some 10 us; cut a hang well beyond that
  initial
  begin
    #200000;
    n_errors++;
    finish_test();
  end
endmodule : tb

`default_nettype wire

// ### testbench/twtu_bus_master.sv
// twtu_bus_master: the one bus master, 80 ns bit period
// assumes the bench forms pulled-up wire levels from all pulls
`default_nettype none

module twtu_bus_master
(
  input wire logic sclW,
  input wire logic sdaW,
  output logic sclPull,
  output logic sdaPull
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    sclPull = 1'b0;
    sdaPull = 1'b0;
  end

  task automatic relScl();
    sclPull = 1'b0;
    for (int k = 0; k < 20000 && sclW !== 1'b1; k++)
      #1;
  endtask : relScl

  task automatic bitIo(input logic b, output logic r);
    sdaPull = ~b;
    #20;
    relScl();
    #40;
    r = sdaW;
    sclPull = 1'b1;
    #20;
  endtask : bitIo

  task automatic xfer(input logic [7:0] o, input logic ackIn, output logic [7:0] i,
    output logic ackOut);
    for (int n = 7; n >= 0; n--)
      bitIo(o[n], i[n]);
    bitIo(ackIn, ackOut);
  endtask : xfer

  // also serves as repeated start
  task automatic start();
    sdaPull = 1'b0;
    #20;
    relScl();
    #40;
    sdaPull = 1'b1;
    #40;
    sclPull = 1'b1;
    #20;
  endtask : start

  task automatic stop();
    sdaPull = 1'b1;
    #20;
    relScl();
    #40;
    sdaPull = 1'b0;
    #40;
  endtask : stop
endmodule : twtu_bus_master

`default_nettype wire

// ### testbench/twtu_sva.sv
// twtu_sva: port checks on the two-wire target, pins and memory reader
// bound into twtu_top; sclIn is the resolved clock wire
`default_nettype none

module twtu_sva
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sclOe,
  input wire logic sdaOe,
  input wire logic memReq,
  input wire logic [31:0] memAddr,
  input wire logic memAck
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_memHold;
    memReq && !memAck |=> memReq && $stable(memAddr);
  endproperty
  a_memHold: assert property (p_memHold)
    else $error("fetch dropped or moved");
  property p_memOnce;
    memReq && memAck |=> !memReq;
  endproperty
  a_memOnce: assert property (p_memOnce)
    else $error("fetch held after answer");
  property p_memDone;
    $fell(memReq) |-> $past(memAck);
  endproperty
  a_memDone: assert property (p_memDone)
    else $error("fetch abandoned");
  // a stretch never starts on a high clock, so no glitch on the wire
  property p_stretchLow;
    $rose(sclOe) |-> !$past(sclIn, 2);
  endproperty
  a_stretchLow: assert property (p_stretchLow)
    else $error("stretch began with clock high");
  property p_dataLow;
    $changed(sdaOe) |-> !$past(sclIn, 2);
  endproperty
  a_dataLow: assert property (p_dataLow)
    else $error("data moved with clock high");
  property p_stretchLen;
    $rose(sclOe) |=> sclOe;
  endproperty
  a_stretchLen: assert property (p_stretchLen)
    else $error("stretch too short");
  property p_relFetched;
    $fell(sclOe) |-> !$past(memReq);
  endproperty
  a_relFetched: assert property (p_relFetched)
    else $error("clock released mid fetch");
  property p_relSettled;
    $fell(sclOe) |-> $stable(sdaOe);
  endproperty
  a_relSettled: assert property (p_relSettled)
    else $error("data not settled at release");
endmodule : twtu_sva

bind twtu_top twtu_sva u_sva (.sys_clk(sys_clk), .rst(rst), .sclIn(sclIn), .sclOe(sclOe),
  .sdaOe(sdaOe), .memReq(memReq), .memAddr(memAddr), .memAck(memAck));

`default_nettype wire
